// ==== hw/wlp_top.sv ====
// Watchdog and low-power mode control, top level
`timescale 1ns/1ps
module wlp_top
  import wlp_pkg::*;
#(
  parameter int HOLD_CYC = int'(RST_HOLD_CYC) // Global reset hold
)
(
  input  wire logic            core_clk,
  input  wire logic            arst_n,
  // Special function register port
  input  wire logic [7:0]      sfr_addr,
  input  wire logic            sfr_wr,
  input  wire logic            sfr_rd,
  input  wire logic [7:0]      sfr_wdata,
  output logic      [7:0]      sfr_rdata,
  // Slow RC clock pin, sampled
  input  wire logic            slow_rc_clock,
  // Software clock configuration
  input  wire logic            slow_rc_stop,
  input  wire logic [NMOD-1:0] sw_clk_en,
  // Enabled interrupt requests from wake sources
  input  wire logic            i2c_irq,
  input  wire logic [2:0]      ext_irq,
  input  wire logic            slow_timer_irq,
  // Clock and module control
  output logic                 fast_rc_clock_en,
  output logic                 pll_en,
  output logic                 slow_rc_clock_en,
  output logic [NMOD-1:0]      module_clk_en,
  // Reset and interrupt outputs
  output logic                 sys_rst_n,
  output logic                 watchdog_reset_flag_set,
  output logic                 watchdog_irq,
  output logic                 wake_pulse
);
  // Carrier to the counter; top drives tick, clear, enable, code
  wlp_wd_if wd ();

  logic [7:0]      low_power_select;    // Sleep control
  logic [7:0]      watchdog_interval;   // Timeout code
  logic [7:0]      watchdog_enable_key; // Enable key
  logic            slow_s1;             // Synchroniser stage 1
  logic            slow_s2;             // Synchroniser stage 2
  logic            slow_s3;             // Edge history
  wlp_state_type   state;               // Reset sequencer
  logic [HOLD_W-1:0] hold_cnt;          // Reset hold counter
  logic            sleeping;            // Low power active
  logic            wake;                // Wake condition
  logic            wd_ovf_rst;          // Overflow in normal mode
  logic            in_hold;             // Global reset held
  logic            wr_lps;              // Write sleep register
  logic            wr_int;              // Write interval register
  logic            wr_key;              // Write key register

  // Write strobes per register
  assign wr_lps = sfr_wr && (sfr_addr == ADDR_LOW_POWER_SELECT);
  assign wr_int = sfr_wr && (sfr_addr == ADDR_WATCHDOG_INTERVAL);
  assign wr_key = sfr_wr && (sfr_addr == ADDR_WATCHDOG_ENABLE_KEY);
  assign in_hold = (state == WLP_HOLD);
  assign sleeping = low_power_select[SLEEP_REQUEST_BIT];

  // Slow clock pin crosses into core clock
  // Stage 1 feeds only stage 2, so a metastable sample never
  // reaches the edge logic; stage 3 just keeps edge history
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      slow_s1 <= 1'b0;
      slow_s2 <= 1'b0;
      slow_s3 <= 1'b0;
    end else begin
      slow_s1 <= slow_rc_clock;
      slow_s2 <= slow_s1;
      slow_s3 <= slow_s2;
    end
  end

  // Rising slow edge is the counting enable
  // Costs two to three core cycles of latency, harmless here
  // Gated off when the slow oscillator is stopped in low power
  assign wd.tick = slow_s2 && !slow_s3 && slow_rc_clock_en;

  // Sleep register: wake clears, software write wins
  // Software is the setter; a wake in the cycle of a sleep
  // write loses, so the core never misses its own request
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_power_select <= RST_LOW_POWER_SELECT;
    end else if (in_hold) begin
      low_power_select <= RST_LOW_POWER_SELECT;
    end else if (wr_lps) begin
      // Only the sleep bit exists, others read zero
      low_power_select <= READ_ZERO;
      low_power_select[SLEEP_REQUEST_BIT] <=
        sfr_wdata[SLEEP_REQUEST_BIT];
    end else if (wake) begin
      low_power_select[SLEEP_REQUEST_BIT] <= 1'b0;
    end
  end

  // Interval register; global reset reloads it
  // Every write also clears the counter, whatever the value
  // Upper five bits are stored and read back but unused
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      watchdog_interval <= RST_WATCHDOG_INTERVAL;
    end else if (in_hold) begin
      watchdog_interval <= RST_WATCHDOG_INTERVAL;
    end else if (wr_int) begin
      watchdog_interval <= sfr_wdata;
    end
  end

  // Enable key register; reset value keeps dog running
  // Any value but the disable key leaves the dog running
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      watchdog_enable_key <= RST_WATCHDOG_ENABLE_KEY;
    end else if (in_hold) begin
      watchdog_enable_key <= RST_WATCHDOG_ENABLE_KEY;
    end else if (wr_key) begin
      watchdog_enable_key <= sfr_wdata;
    end
  end

  // Counter control over the interface
  // Clear stays high through the hold so counting restarts at zero
  assign wd.en = (watchdog_enable_key != WD_DISABLE_KEY);
  assign wd.clr = wr_int || in_hold;
  assign wd.interval =
    watchdog_interval[INTERVAL_LSB +: INTERVAL_W];

  wlp_wd_counter u_counter (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .wd       (wd.cnt)
  );

  // Overflow splits into reset or wake interrupt
  // Overflows during the hold are dropped; the counter is cleared
  assign wd_ovf_rst = wd.ovf && !sleeping && !in_hold;

  // Wake sources; stopped slow clock leaves only external
  // Inputs are already enabled requests from their own blocks
  // Watchdog wake needs the slow clock, so it drops out with it
  always_comb begin
    if (slow_rc_stop) begin
      wake = sleeping && (|ext_irq);
    end else begin
      wake = sleeping && (i2c_irq || (|ext_irq) || slow_timer_irq ||
             (wd.ovf && !in_hold));
    end
  end

  // Reset sequencer: hold global reset after overflow
  // Hold length is a parameter so benches can shorten it
  // Counter width covers the full default hold
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= WLP_RUN;
      hold_cnt <= '0;
    end else begin
      unique case (state)
        WLP_RUN: begin
          // Counter parked at zero while running
          hold_cnt <= '0;
          if (wd_ovf_rst) begin
            state <= WLP_HOLD;
          end
        end
        WLP_HOLD: begin
          // Count the full hold before release
          if (hold_cnt == HOLD_W'(HOLD_CYC - 1)) begin
            state <= WLP_RUN;
          end else begin
            hold_cnt <= hold_cnt + 1'b1;
          end
        end
      endcase
    end
  end

  // Registered reset and event outputs
  // Registered so the global reset never glitches on decode
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_rst_n               <= 1'b0;
      watchdog_reset_flag_set <= 1'b0;
      watchdog_irq            <= 1'b0;
      wake_pulse              <= 1'b0;
    end else begin
      sys_rst_n               <= !in_hold && !wd_ovf_rst;
      watchdog_reset_flag_set <= wd_ovf_rst;
      watchdog_irq <= wd.ovf && sleeping && !in_hold;
      // Core services this interrupt then resumes
      wake_pulse <= wake;
    end
  end

  // Fast clocks follow the mode
  // Combinational: the sleep bit itself is a flip-flop
  assign fast_rc_clock_en = !sleeping;
  assign pll_en           = !sleeping;
  assign slow_rc_clock_en = !(sleeping && slow_rc_stop);

  // Per-module gating, low power keeps a few only
  // Mask keeps slow timer, second serial, watchdog and I2C
  always_comb begin
    if (sleeping) begin
      module_clk_en = sw_clk_en & LP_KEEP_MASK;
    end else begin
      module_clk_en = sw_clk_en;
    end
  end

  // Read data registered; unmapped reads zero
  // One cycle latency; value holds until the next read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= READ_ZERO;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_LOW_POWER_SELECT:    sfr_rdata <= low_power_select;
        ADDR_WATCHDOG_INTERVAL:   sfr_rdata <= watchdog_interval;
        ADDR_WATCHDOG_ENABLE_KEY: sfr_rdata <= watchdog_enable_key;
        default:                  sfr_rdata <= READ_ZERO;
      endcase
    end
  end

  // Properties on the core clock; reset disables them
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // Sleep write takes effect on the next cycle
  a_sleep_enter: assert property (
    wr_lps && sfr_wdata[SLEEP_REQUEST_BIT] && !in_hold |=> sleeping)
    else $error("sleep write did not enter low power");

  // Wake clears the sleep bit and pulses the core
  a_wake_clears: assert property (
    wake && !wr_lps && !in_hold |=> !sleeping && wake_pulse)
    else $error("wake did not clear sleep bit");

  // Fast clocks and core stopped in low power
  a_fast_clk_off: assert property (
    sleeping |-> !fast_rc_clock_en && !pll_en &&
    !module_clk_en[M_CORE])
    else $error("fast clocks running in low power");

  // Stopped modules never enabled in low power
  a_lp_module_gate: assert property (
    sleeping |-> (module_clk_en & ~LP_KEEP_MASK) == '0)
    else $error("stopped module enabled in low power");

  // All clocks stopped: other sources cannot wake
  a_ext_only_wake: assert property (
    sleeping && slow_rc_stop && ext_irq == '0 |-> !wake)
    else $error("wake without external interrupt");

  // Disable key stops counting from the next cycle
  a_key_disable: assert property (
    wr_key && sfr_wdata == WD_DISABLE_KEY && !in_hold |=> !wd.en)
    else $error("disable key ignored");

  // Normal overflow drops the global reset at once
  a_ovf_reset: assert property (
    wd_ovf_rst |=> !sys_rst_n && watchdog_reset_flag_set ##1
    !sys_rst_n [*8])
    else $error("overflow did not hold reset");

  // Low-power overflow is an interrupt, not a reset
  a_ovf_irq: assert property (
    wd.ovf && sleeping && !in_hold |=> watchdog_irq && sys_rst_n)
    else $error("low power overflow not an interrupt");

  // End of hold releases reset with the dog enabled
  a_hold_release: assert property (
    $fell(in_hold) |=> sys_rst_n && wd.en)
    else $error("reset not released after hold");

  // Active mode passes software gating straight through
  a_active_clocks: assert property (
    !sleeping |-> fast_rc_clock_en && pll_en && module_clk_en == sw_clk_en)
    else $error("active mode clock enables wrong");

  // Kept modules still follow their software enables
  a_kept_modules: assert property (
    sleeping |->
    (module_clk_en & LP_KEEP_MASK) == (sw_clk_en & LP_KEEP_MASK))
    else $error("kept module gating wrong in low power");

  // Only the sleep bit of the select register can be set
  a_sleep_upper: assert property (
    (low_power_select >> (SLEEP_REQUEST_BIT + 1)) == '0)
    else $error("reserved sleep register bits set");

  // Reset flag request is a single pulse per overflow
  a_flag_pulse: assert property (
    watchdog_reset_flag_set |=> !watchdog_reset_flag_set)
    else $error("reset flag request longer than one cycle");

  // Interrupt is one cycle and never pairs with a reset
  a_irq_pulse: assert property (
    watchdog_irq |-> !watchdog_reset_flag_set ##1 !watchdog_irq)
    else $error("watchdog interrupt malformed");

  // No global reset while sleeping outside a hold
  a_sleep_no_reset: assert property (
    sleeping && !in_hold |=> sys_rst_n)
    else $error("global reset raised in low power");

  // Global reset stays low for the whole hold
  a_hold_rst_low: assert property (
    in_hold |-> !sys_rst_n)
    else $error("global reset released during hold");

  // Hold reloads registers and leaves the dog enabled
  a_hold_regs: assert property (
    in_hold |=> low_power_select == RST_LOW_POWER_SELECT &&
    watchdog_interval == RST_WATCHDOG_INTERVAL && wd.en)
    else $error("registers not reloaded by hold");

  // Watchdog interrupt always comes with a wake
  a_irq_wakes: assert property (
    watchdog_irq |-> wake_pulse)
    else $error("watchdog interrupt without wake");

  // External request wakes a sleeping chip
  a_ext_wake: assert property (
    sleeping && ext_irq != '0 |=> wake_pulse)
    else $error("external request did not wake");

  // Wake pulse only follows a sleeping cycle
  a_wake_needs_sleep: assert property (
    wake_pulse |-> $past(sleeping))
    else $error("wake pulse while active");

  // Stopped slow oscillator gives no counting edges
  a_tick_gated: assert property (
    !slow_rc_clock_en |-> !wd.tick)
    else $error("watchdog tick with slow clock stopped");

  c_sleep_wake: cover property (sleeping ##1 !sleeping);
  c_wd_reset: cover property (wd_ovf_rst);
  c_wd_irq: cover property (watchdog_irq);
  c_key_off: cover property (wr_key && sfr_wdata == WD_DISABLE_KEY);
endmodule

// ==== hw/wlp_pkg.sv ====
// Constants and types for the watchdog and low-power mode block
// Summary of operation
// - Sleep bit enters low power, wake clears
// - Low power stops fast clocks and core
// - Active mode runs fast clocks, modules configured
// - Only four modules may run in low power
// - Software gates each module clock individually
// - Enabled wake interrupts end low power
// - Core resumes through the waking interrupt
// - Slow clock stopped: only external interrupts wake
// - Watchdog counts on slow RC clock
// - Interval code selects 18 ms doubling timeouts
// - Normal overflow asserts global reset
// - Low-power overflow raises wake interrupt instead
// - Interval write or global reset clears counter
// - Counter clear released on slow clock
// - Counter restarts after overflow while enabled
// - Key 0x55 disables, else enables watchdog
// - Watchdog runs after reset, key 0x00
// - Overflow reset holds global reset 20 ms
// - Overflow reset sets watchdog reset flag
package wlp_pkg;
  // Register addresses on the special function bus
  localparam logic [7:0] ADDR_LOW_POWER_SELECT    = 8'h87;
  localparam logic [7:0] ADDR_WATCHDOG_INTERVAL   = 8'h91;
  localparam logic [7:0] ADDR_WATCHDOG_ENABLE_KEY = 8'h92;
  // Reset values
  localparam logic [7:0] RST_LOW_POWER_SELECT    = 8'h00;
  localparam logic [7:0] RST_WATCHDOG_INTERVAL   = 8'h00;
  localparam logic [7:0] RST_WATCHDOG_ENABLE_KEY = 8'h00;
  // Field positions and key
  localparam int         SLEEP_REQUEST_BIT = 0;
  localparam int         INTERVAL_LSB      = 0;
  localparam int         INTERVAL_W        = 3;
  localparam logic [7:0] WD_DISABLE_KEY    = 8'h55;
  localparam logic [7:0] READ_ZERO         = 8'h00;
  // Timing: core clock, slow clock and their counts
  localparam longint CORE_CLK_HZ = 20000000;
  localparam longint SLOW_CLK_HZ = 32768;
  localparam longint WD_BASE_MS  = 18;
  localparam longint RST_HOLD_MS = 20;
  localparam int     CNT_W       = 17;
  localparam logic [CNT_W-1:0] WD_BASE_CYC =
    CNT_W'(SLOW_CLK_HZ * WD_BASE_MS / 1000);
  localparam int     HOLD_W      = 20;
  localparam longint RST_HOLD_CYC = CORE_CLK_HZ * RST_HOLD_MS / 1000;
  // Module clock enable bit order
  localparam int NMOD = 11;
  localparam int M_SLOW_TIMER = 0;
  localparam int M_SERIAL2    = 1;
  localparam int M_WATCHDOG   = 2;
  localparam int M_I2C        = 3;
  localparam int M_CORE       = 4;
  // Modules allowed to run in low power
  localparam logic [NMOD-1:0] LP_KEEP_MASK = 11'h00F;
  // Reset sequencer states
  typedef enum logic {WLP_RUN, WLP_HOLD} wlp_state_type;
endpackage

// ==== hw/wlp_wd_if.sv ====
// Interface between mode control and the watchdog counter
`timescale 1ns/1ps
interface wlp_wd_if;
  import wlp_pkg::*;
  logic                  tick;     // Slow clock edge enable
  logic                  clr;      // Clear request, high for an interval write and through the hold
  logic                  en;       // Count enable
  logic [INTERVAL_W-1:0] interval; // Timeout code
  logic                  ovf;      // Overflow pulse
  modport ctrl (output tick, clr, en, interval, input ovf);
  modport cnt  (input tick, clr, en, interval, output ovf);
endinterface

// ==== hw/wlp_wd_counter.sv ====
// Watchdog counter running on slow clock enables
`timescale 1ns/1ps
module wlp_wd_counter
  import wlp_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  wlp_wd_if.cnt    wd
);
  logic [CNT_W-1:0] count;    // Slow tick count
  logic             clr_pend; // Clear waiting for slow edge

  // Terminal count doubles per code step
  function automatic logic [CNT_W-1:0] term_of(
    input logic [INTERVAL_W-1:0] code);
    term_of = WD_BASE_CYC << code;
  endfunction

  // Pending clear, set wins over release
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      clr_pend <= 1'b1;
    end else if (wd.clr) begin
      clr_pend <= 1'b1;
    end else if (wd.tick) begin
      clr_pend <= 1'b0;
    end
  end

  // Counter advances only on slow edges
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (wd.tick) begin
      if (clr_pend) begin
        count <= '0;
      end else if (wd.en) begin
        if (count == term_of(wd.interval) - 1'b1) begin
          count <= '0;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

  // Overflow pulse one core cycle long
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd.ovf <= 1'b0;
    end else begin
      wd.ovf <= wd.tick && wd.en && !clr_pend && !wd.clr &&
                (count == term_of(wd.interval) - 1'b1);
    end
  end

  a_ovf_needs_en: assert property (@(posedge core_clk)
    disable iff (!arst_n) wd.ovf |-> $past(wd.en))
    else $error("overflow while watchdog disabled");
  a_clear_on_tick: assert property (@(posedge core_clk)
    disable iff (!arst_n) (clr_pend && wd.tick) |=> count == '0)
    else $error("counter not cleared on slow edge");
  a_count_hold: assert property (@(posedge core_clk)
    disable iff (!arst_n) !wd.en && !clr_pend |=> $stable(count))
    else $error("counter moved while disabled");
  a_wrap_restart: assert property (@(posedge core_clk)
    disable iff (!arst_n) wd.ovf |-> count == '0)
    else $error("counter did not restart after overflow");
  c_overflow: cover property (@(posedge core_clk) wd.ovf);
endmodule

// ==== sim/wlp_top_test.sv ====
// Self-checking testbench for the watchdog and low-power mode block
`timescale 1ns/1ps
module wlp_top_test;
  import wlp_pkg::*;
  localparam int HOLD = 16;        // Short reset hold keeps the run brief
  logic            core_clk;
  logic            arst_n;
  logic [7:0]      sfr_addr;
  logic            sfr_wr;
  logic            sfr_rd;
  logic [7:0]      sfr_wdata;
  logic [7:0]      sfr_rdata;
  logic            slow_rc_clock;
  logic            slow_rc_stop;
  logic [NMOD-1:0] sw_clk_en;
  logic            i2c_irq;
  logic [2:0]      ext_irq;
  logic            slow_timer_irq;
  logic            fast_rc_clock_en;
  logic            pll_en;
  logic            slow_rc_clock_en;
  logic [NMOD-1:0] module_clk_en;
  logic            sys_rst_n;
  logic            watchdog_reset_flag_set;
  logic            watchdog_irq;
  logic            wake_pulse;
  int              failures;       // Mismatch count
  int              checks;         // Comparison count
  int              ticks;          // Slow clock rising edges seen
  bit              slow_run;       // Slow pin toggles only when set
  logic [1:0]      div;            // Slow pin divider
  int              t0;
  int              n;
  int              k;

  wlp_top #(.HOLD_CYC(HOLD)) u_dut (
    .core_clk(core_clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .slow_rc_clock(slow_rc_clock),
    .slow_rc_stop(slow_rc_stop), .sw_clk_en(sw_clk_en),
    .i2c_irq(i2c_irq), .ext_irq(ext_irq), .slow_timer_irq(slow_timer_irq),
    .fast_rc_clock_en(fast_rc_clock_en), .pll_en(pll_en),
    .slow_rc_clock_en(slow_rc_clock_en), .module_clk_en(module_clk_en),
    .sys_rst_n(sys_rst_n), .watchdog_reset_flag_set(watchdog_reset_flag_set),
    .watchdog_irq(watchdog_irq), .wake_pulse(wake_pulse)
  );

  // 20 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Slow pin at one eighth of the core rate, so watchdog counts stay short
  always @(negedge core_clk) begin
    if (slow_run) begin
      div = div + 2'h1;
      if (div == 2'h0) slow_rc_clock = ~slow_rc_clock;
    end
  end
  always @(posedge slow_rc_clock) ticks++;

  // Single comparison point, counts every call
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One-cycle write strobe, driven on the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask

  // Read: data is registered one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    sfr_addr = a; sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    check(16'(sfr_rdata), 16'(exp));
  endtask

  // Wait for an overflow event; dt is slow ticks since t0
  task automatic wait_ev(input bit irq_mode, output int dt);
    for (int i = 0; i < 20000; i++) begin
      @(negedge core_clk);
      if (irq_mode && !sys_rst_n) check(16'h0, 16'h1);
      if (irq_mode ? watchdog_irq === 1'b1 : sys_rst_n === 1'b0) break;
    end
    dt = ticks - t0;
  endtask

  // Reset hold length and flag pulse after an overflow reset
  task automatic check_hold();
    int c;
    c = 0;
    check(16'(watchdog_reset_flag_set), 16'h1);
    while (sys_rst_n !== 1'b1 && c < 1000) begin
      @(negedge core_clk);
      c++;
    end
    check(16'(c), 16'(HOLD + 1));
    check(16'(watchdog_reset_flag_set), 16'h0);
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0; sfr_addr = 8'h00; sfr_wr = 1'b0; sfr_rd = 1'b0;
    sfr_wdata = 8'h00; slow_rc_clock = 1'b0; slow_rc_stop = 1'b0;
    sw_clk_en = 11'h5A5; i2c_irq = 1'b0; ext_irq = 3'h0;
    slow_timer_irq = 1'b0; slow_run = 1'b0; div = 2'h0; ticks = 0;
    failures = 0; checks = 0;
    repeat (5) @(negedge core_clk);
    arst_n = 1'b1;
    // Defaults after reset, unmapped address reads zero
    rd(8'h87, 8'h00);
    rd(8'h91, 8'h00);
    rd(8'h92, 8'h00);
    rd(8'h93, 8'h00);
    check(16'({fast_rc_clock_en, pll_en}), 16'h3);
    check(16'(module_clk_en), 16'h05A5);
    // Each wake source ends low power
    for (k = 0; k < 5; k++) begin
      wr(8'h87, 8'h01);
      check(16'({fast_rc_clock_en, pll_en, slow_rc_clock_en}), 16'h1);
      check(16'(module_clk_en), 16'h0005);
      {slow_timer_irq, ext_irq, i2c_irq} = 5'(1 << k);
      @(negedge core_clk);
      {slow_timer_irq, ext_irq, i2c_irq} = 5'h00;
      check(16'({wake_pulse, fast_rc_clock_en, pll_en}), 16'h7);
      rd(8'h87, 8'h00);
    end
    // Slow clock stopped: only external interrupts wake
    slow_rc_stop = 1'b1;
    wr(8'h87, 8'h01);
    check(16'(slow_rc_clock_en), 16'h0);
    i2c_irq = 1'b1;
    @(negedge core_clk);
    i2c_irq = 1'b0;
    @(negedge core_clk);
    check(16'(fast_rc_clock_en), 16'h0);
    ext_irq = 3'h4;
    @(negedge core_clk);
    ext_irq = 3'h0;
    check(16'({wake_pulse, fast_rc_clock_en}), 16'h3);
    slow_rc_stop = 1'b0;
    // Key 0x55 stops the watchdog
    wr(8'h92, 8'h55);
    rd(8'h92, 8'h55);
    slow_run = 1'b1;
    t0 = ticks;
    n = 0;
    while (ticks - t0 < 700) begin
      @(negedge core_clk);
      if (sys_rst_n !== 1'b1) n++;
    end
    check(16'(n), 16'h0);
    // Other key enables; interval write clears, 18 ms count
    wr(8'h92, 8'h12);
    wr(8'h91, 8'h00);
    t0 = ticks;
    wait_ev(1'b0, n);
    check(16'(n >= 589 && n <= 591), 16'h1);
    check_hold();
    rd(8'h92, 8'h00);
    // Code 1 doubles; a mid-way rewrite restarts timing
    wr(8'h91, 8'h01);
    t0 = ticks;
    while (ticks - t0 < 500) @(negedge core_clk);
    wr(8'h91, 8'h01);
    t0 = ticks;
    wait_ev(1'b0, n);
    check(16'(n >= 1178 && n <= 1180), 16'h1);
    check_hold();
    rd(8'h91, 8'h00);
    // Overflow while sleeping wakes instead of resetting
    wr(8'h91, 8'h00);
    wr(8'h87, 8'h01);
    t0 = ticks;
    wait_ev(1'b1, n);
    check(16'(n >= 589 && n <= 591), 16'h1);
    check(16'({watchdog_irq, wake_pulse, fast_rc_clock_en, sys_rst_n}),
          16'hF);
    @(negedge core_clk);
    check(16'({watchdog_irq, wake_pulse}), 16'h0);
    rd(8'h87, 8'h00);
    // Counting restarts after the overflow
    t0 = ticks;
    wait_ev(1'b0, n);
    check(16'(n >= 585 && n <= 590), 16'h1);
    check_hold();
    end_sim();
  end

  // Hang guard, well beyond the expected run length
  initial begin
    repeat (80000) @(posedge core_clk);
    failures++;
    end_sim();
  end
endmodule
